/* File: src/tlc_pkg.sv */
/*
  tlc package: auxiliary command codes, address modes, command byte fields
  and status bit positions for the talk/listen/control state logic.
  assumes nothing of its surroundings beyond a single synchronous clock.
*/
package tlc_pkg;
  // address modes (low two bits of the address mode setting)
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_ONE = 2'h1;
  localparam logic [1:0] MODE_TWO = 2'h2;
  localparam logic [1:0] MODE_THREE = 2'h3;
  // auxiliary command codes accepted on the command strobe
  localparam logic [3:0] AUX_NOP = 4'h0;
  localparam logic [3:0] AUX_TCA = 4'h1;      // take control asynchronously
  localparam logic [3:0] AUX_TCS = 4'h2;      // take control synchronously
  localparam logic [3:0] AUX_GTS = 4'h3;      // go to standby
  localparam logic [3:0] AUX_LISTEN = 4'h4;
  localparam logic [3:0] AUX_LUNL = 4'h5;     // local unlisten
  localparam logic [3:0] AUX_VALID = 4'h6;
  localparam logic [3:0] AUX_NONVALID = 4'h7;
  localparam logic [3:0] AUX_BECOME_CIC = 4'h8;
  // bus command byte groups (bits 6:5)
  localparam logic [1:0] GRP_UNIV = 2'h0;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SECOND = 2'h3;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 5;
  localparam logic [7:0] CMD_TCT = 8'h09;
  localparam logic [4:0] ADDR_UNADDR = 5'h1f;
  // address status bit positions
  localparam int AS_MAJOR_MINOR_SELECT_BIT = 0;
  localparam int AS_TA = 1;
  localparam int AS_LA = 2;
  localparam int AS_TALK_PRIMARY_SEEN_BIT = 3;
  localparam int AS_LISTEN_PRIMARY_SEEN_BIT = 4;
  localparam int AS_ATN_N = 5;
  localparam int AS_CIC = 6;
  localparam int AS_W = 7;
  // status flag positions in the event vector
  localparam int EV_DI = 0;
  localparam int EV_DO = 1;
  localparam int EV_CO = 2;
  localparam int EV_ADDRESS_CHANGE_FLAG = 3;
  localparam int EV_APT = 4;
  localparam int EV_END = 5;
  localparam int EV_W = 6;
  // fifo geometry
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 4;
  // controller states
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_ACTIVE = 2'b01,
    CS_STANDBY = 2'b10,
    CS_SYNC_WAIT = 2'b11
  } tlc_ctrl_t;
endpackage : tlc_pkg

/* File: src/tlc_fifo.sv */
/*
  tlc fifo: small flop-based first-in first-out buffer with valid/ready on
  both sides. assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module tlc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;  // occupancy, one bit wider than pointers
  wire do_push = in_valid && in_ready;
  wire do_pop = out_valid && out_ready;
  assign in_ready = (count != DEPTH[AW:0]);  // honest full
  assign out_valid = (count != '0);  // honest empty
  assign out_data = mem[rd_ptr];

  ////////////////////////////////////////////////////////////////////////
  // pointers and count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (do_pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end

  // storage write; no reset needed for data
  always_ff @(posedge clk) begin
    if (do_push) mem[wr_ptr] <= in_data;
  end
endmodule : tlc_fifo

/* File: src/tlc_core.sv */
/*
  tlc core: talker/listener/controller state logic of one bus port.
  assumes bus command bytes arrive as one-cycle strobes after handshake
  acceptance, data-byte completion is reported by the handshake engine,
  and software clears status flags with a one-cycle clear strobe.
*/
`timescale 1ns/1ps
module tlc_core
  import tlc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // configuration
  input wire logic [1:0] address_mode_reg,
  input wire logic talk_only,
  input wire logic listen_only,
  input wire logic [4:0] first_address_reg,
  input wire logic [4:0] second_address_reg,
  // auxiliary command strobe
  input wire logic aux_valid,
  input wire logic [3:0] aux_cmd,
  // status clear strobe (one bit per flag)
  input wire logic [EV_W-1:0] flag_clear,
  // bus side: received command and data events
  input wire logic bus_cmd_valid,
  input wire logic [7:0] bus_cmd,
  input wire logic bus_atn_in,
  input wire logic bus_byte_done,
  input wire logic bus_end_seen,
  // received data stream into fifo
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // received data stream to software
  output logic host_rx_valid,
  input wire logic host_rx_ready,
  output logic [7:0] host_rx_data,
  // outputs
  output logic atn_out,
  output logic dac_holdoff,
  output logic [AS_W-1:0] address_status_reg,
  output logic [EV_W-1:0] status_flags,
  output logic [7:0] command_pass_through_reg
);
  ////////////////////////////////////////////////////////////////////////
  // state
  tlc_ctrl_t ctrl, next_ctrl;  // controller function
  logic talker_addressed_bit;
  logic listener_addressed_bit;
  logic talk_primary_seen_bit;
  logic listen_primary_seen_bit;
  logic major_minor_select_bit;
  logic holdoff;  // dac held false pending valid/non-valid
  logic tct_pending;  // tct sent, waiting for its acceptance
  logic [7:0] cpt;  // last passed-through secondary

  ////////////////////////////////////////////////////////////////////////
  // command decode
  wire aux_tca = aux_valid && (aux_cmd == AUX_TCA);
  wire aux_tcs = aux_valid && (aux_cmd == AUX_TCS);
  wire aux_gts = aux_valid && (aux_cmd == AUX_GTS);
  wire aux_listen = aux_valid && (aux_cmd == AUX_LISTEN);
  wire aux_lunl = aux_valid && (aux_cmd == AUX_LUNL);
  wire aux_ok = aux_valid && (aux_cmd == AUX_VALID) && holdoff;
  wire aux_bad = aux_valid && (aux_cmd == AUX_NONVALID) && holdoff;
  wire aux_cic = aux_valid && (aux_cmd == AUX_BECOME_CIC);
  wire [1:0] grp = bus_cmd[6:5];
  wire [4:0] adr = bus_cmd[ADDR_LSB +: ADDR_W];
  wire cmd_talk = bus_cmd_valid && (grp == GRP_TALK);
  wire cmd_listen = bus_cmd_valid && (grp == GRP_LISTEN);
  wire cmd_second = bus_cmd_valid && (grp == GRP_SECOND);
  wire cmd_primary = bus_cmd_valid && !cmd_second;
  wire cmd_tct = bus_cmd_valid && (bus_cmd == CMD_TCT);
  wire hit_major = (adr == first_address_reg);
  wire hit_minor = (adr == second_address_reg);
  // mode two has a single primary; modes one and three have two
  wire mode_1 = (address_mode_reg == MODE_ONE);
  wire mode_2 = (address_mode_reg == MODE_TWO);
  wire mode_3 = (address_mode_reg == MODE_THREE);
  wire prim_hit = mode_2 ? hit_major : (hit_major || hit_minor);
  wire unlisten = cmd_listen && (adr == ADDR_UNADDR);
  wire untalk = cmd_talk && (adr == ADDR_UNADDR);
  wire my_talk = cmd_talk && !untalk && prim_hit;
  wire my_listen = cmd_listen && !unlisten && prim_hit;
  wire other_talk = cmd_talk && !my_talk;  // another talker or untalk was named
  // mode two secondary compares with the second address register
  wire sec_hit = (adr == second_address_reg);
  wire any_pas = talk_primary_seen_bit || listen_primary_seen_bit;
  wire m2_sec_ok = mode_2 && cmd_second && any_pas && sec_hit;
  wire m2_sec_bad = mode_2 && cmd_second && any_pas && !sec_hit;
  wire m3_sec = mode_3 && cmd_second && any_pas;
  wire in_charge = (ctrl == CS_ACTIVE);

  ////////////////////////////////////////////////////////////////////////
  // talker / listener selection
  // set requests (activating either one clears the other)
  wire set_ta = (mode_1 && my_talk) || (m2_sec_ok && talk_primary_seen_bit) ||
                (aux_ok && talk_primary_seen_bit);
  wire set_la = (mode_1 && my_listen) || (m2_sec_ok && listen_primary_seen_bit) ||
                (aux_ok && listen_primary_seen_bit) ||
                (aux_listen && in_charge);
  wire clr_ta = other_talk || untalk || (aux_bad && talk_primary_seen_bit) ||
                (m2_sec_bad && talk_primary_seen_bit);
  wire clr_la = unlisten || (aux_lunl && in_charge) ||
                (aux_bad && listen_primary_seen_bit) ||
                (m2_sec_bad && listen_primary_seen_bit);
  // talk-only / listen-only override addressing
  wire next_ta = talk_only ? 1'b1 : listen_only ? 1'b0 :
                 set_ta ? 1'b1 : (set_la || clr_ta) ? 1'b0 : talker_addressed_bit;
  wire next_la = talk_only ? 1'b0 : listen_only ? 1'b1 :
                 set_ta ? 1'b0 : set_la ? 1'b1 : clr_la ? 1'b0 : listener_addressed_bit;
  // primary-seen bits (modes two and three only): set on own primary, cleared by any other primary
  wire use_ext = mode_2 || mode_3;
  wire next_talk_primary_seen_bit = (use_ext && cmd_primary) ? my_talk : talk_primary_seen_bit;
  wire next_listen_primary_seen_bit = (use_ext && cmd_primary) ? my_listen : listen_primary_seen_bit;
  wire next_major_minor_select_bit = ((my_talk || my_listen) && !mode_2) ? (!hit_major && hit_minor)
                   : major_minor_select_bit;
  wire addr_change = (next_ta != talker_addressed_bit) ||
                     (next_la != listener_addressed_bit);

  ////////////////////////////////////////////////////////////////////////
  // controller function
  always_comb begin
    next_ctrl = ctrl;
    unique case (ctrl)
      CS_IDLE: begin
        if (aux_cic) next_ctrl = CS_ACTIVE;
      end
      CS_ACTIVE: begin
        if (tct_pending && bus_byte_done) next_ctrl = CS_IDLE;
        else if (aux_gts) next_ctrl = CS_STANDBY;
      end
      CS_STANDBY: begin
        if (aux_tca) next_ctrl = CS_ACTIVE;
        else if (aux_tcs) next_ctrl = CS_SYNC_WAIT;
      end
      CS_SYNC_WAIT: begin
        // atn after the current byte completes or at holdoff on end, or at once on tca
        if (aux_tca) next_ctrl = CS_ACTIVE;
        else if (bus_byte_done || bus_end_seen) next_ctrl = CS_ACTIVE;
      end
    endcase
  end
  wire regain = (next_ctrl == CS_ACTIVE) && (ctrl != CS_ACTIVE);

  ////////////////////////////////////////////////////////////////////////
  // event sources; set wins over clear
  logic [EV_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[EV_CO] = regain || (in_charge && bus_byte_done && !tct_pending);
    ev[EV_ADDRESS_CHANGE_FLAG] = addr_change;
    ev[EV_APT] = m3_sec;
    ev[EV_DO] = (set_ta && !talker_addressed_bit) ||
                (talker_addressed_bit && !bus_atn_in && bus_byte_done);  // data bytes move only with atn released
    ev[EV_DI] = host_rx_valid && !status_flags[EV_DI] && listener_addressed_bit;
    ev[EV_END] = bus_end_seen;
  end
  wire [EV_W-1:0] next_flags = ev | (status_flags & ~flag_clear);

  ////////////////////////////////////////////////////////////////////////
  // registers, part one: controller and addressing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= CS_IDLE;
      talker_addressed_bit <= 1'b0;
      listener_addressed_bit <= 1'b0;
      talk_primary_seen_bit <= 1'b0;
      listen_primary_seen_bit <= 1'b0;
      major_minor_select_bit <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      talker_addressed_bit <= next_ta;
      listener_addressed_bit <= next_la;
      talk_primary_seen_bit <= next_talk_primary_seen_bit;
      listen_primary_seen_bit <= next_listen_primary_seen_bit;
      major_minor_select_bit <= next_major_minor_select_bit;
    end
  end

  // registers, part two: holdoff, pass-through and flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      holdoff <= 1'b0;
      tct_pending <= 1'b0;
      cpt <= 8'h00;
      status_flags <= '0;
    end else begin
      // a mode-three secondary after an own primary re-arms the holdoff; valid/non-valid releases it
      holdoff <= m3_sec ? 1'b1 : (aux_ok || aux_bad) ? 1'b0 : holdoff;
      if (m3_sec) cpt <= bus_cmd;
      // tct written while in charge; released once ctrl leaves CS_ACTIVE
      tct_pending <= (in_charge && cmd_tct) ? 1'b1 :
                     (ctrl != CS_ACTIVE) ? 1'b0 : tct_pending;
      status_flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs from flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      atn_out <= 1'b0;
      dac_holdoff <= 1'b0;
      address_status_reg <= '0;
      command_pass_through_reg <= 8'h00;
    end else begin
      atn_out <= (next_ctrl == CS_ACTIVE);
      dac_holdoff <= m3_sec ? 1'b1 : (aux_ok || aux_bad) ? 1'b0 : holdoff;
      address_status_reg[AS_TA] <= next_ta;
      address_status_reg[AS_LA] <= next_la;
      address_status_reg[AS_TALK_PRIMARY_SEEN_BIT] <= next_talk_primary_seen_bit;
      address_status_reg[AS_LISTEN_PRIMARY_SEEN_BIT] <= next_listen_primary_seen_bit;
      address_status_reg[AS_MAJOR_MINOR_SELECT_BIT] <= next_major_minor_select_bit;
      address_status_reg[AS_ATN_N] <= !bus_atn_in;
      address_status_reg[AS_CIC] <= (next_ctrl != CS_IDLE);
      command_pass_through_reg <= m3_sec ? bus_cmd : cpt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // received data buffer; its full state stalls the bus handshake
  tlc_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_rx_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_data),
    .out_valid(host_rx_valid),
    .out_ready(host_rx_ready),
    .out_data(host_rx_data)
  );
endmodule : tlc_core

/* File: testbench/tlc_core_props.sv */
/* tlc core checker: port relations of tlc_core over time.
   assumes the bind below attaches it to every tlc_core. */
`timescale 1ns/1ps
module tlc_core_props
  import tlc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // inputs
  input wire logic [1:0] address_mode_reg,
  input wire logic talk_only,
  input wire logic [4:0] first_address_reg,
  input wire logic [4:0] second_address_reg,
  input wire logic aux_valid,
  input wire logic [3:0] aux_cmd,
  input wire logic bus_cmd_valid,
  input wire logic [7:0] bus_cmd,
  input wire logic bus_atn_in,
  input wire logic bus_byte_done,
  input wire logic bus_end_seen,
  // outputs
  input wire logic atn_out,
  input wire logic dac_holdoff,
  input wire logic [AS_W-1:0] address_status_reg,
  input wire logic [EV_W-1:0] status_flags,
  input wire logic [7:0] command_pass_through_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // decoded helpers
  wire [AS_W-1:0] st = address_status_reg;
  wire standby = st[AS_CIC] && !atn_out; // in charge but atn dropped
  wire [1:0] grp = bus_cmd[6:5];
  wire own = bus_cmd[4:0] == first_address_reg || bus_cmd[4:0] == second_address_reg;
  wire any_ps = st[AS_TALK_PRIMARY_SEEN_BIT] || st[AS_LISTEN_PRIMARY_SEEN_BIT];
  logic tct_seen; // tct byte passed while active, acceptance still due
  always_ff @(posedge clk) begin
    if (sys_rst || !atn_out) tct_seen <= 1'b0;
    else if (bus_cmd_valid && bus_cmd == CMD_TCT) tct_seen <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // properties
  one_role_a: assert property (!(st[AS_TA] && st[AS_LA])) else $error("talker and listener together");
  atn_status_a: assert property (!$past(sys_rst) |-> st[AS_ATN_N] == !$past(bus_atn_in))
    else $error("atn status wrong");
  async_take_a: assert property (aux_valid && aux_cmd == AUX_TCA && standby |=> atn_out)
    else $error("async take ignored");
  sync_hold_a: assert property (aux_valid && aux_cmd == AUX_TCS && standby && !bus_byte_done && !bus_end_seen
    |=> !atn_out) else $error("sync take broke byte");
  co_on_take_a: assert property ($rose(atn_out) |-> ##[0:1] status_flags[EV_CO]) else $error("no co flag");
  tct_release_a: assert property (tct_seen && atn_out && bus_byte_done |=> !atn_out && !st[AS_CIC])
    else $error("tct kept control");
  mode_one_talk_a: assert property (address_mode_reg == MODE_ONE && bus_cmd_valid && grp == GRP_TALK &&
    bus_cmd[4:0] == first_address_reg |=> st[AS_TA] && status_flags[EV_ADDRESS_CHANGE_FLAG] && status_flags[EV_DO])
    else $error("talk address missed");
  pass_through_a: assert property (address_mode_reg == MODE_THREE && bus_cmd_valid && grp == GRP_SECOND && any_ps
    |=> status_flags[EV_APT] && dac_holdoff && command_pass_through_reg == $past(bus_cmd))
    else $error("secondary not passed");
  valid_addr_a: assert property (aux_valid && aux_cmd == AUX_VALID && dac_holdoff && st[AS_TALK_PRIMARY_SEEN_BIT]
    |=> st[AS_TA] && !dac_holdoff) else $error("valid not applied");
  primary_clear_a: assert property (address_mode_reg == MODE_THREE && bus_cmd_valid && grp != GRP_SECOND && !own
    |=> !any_ps) else $error("primary seen kept");
  talk_only_a: assert property (talk_only && $past(talk_only) && !$past(sys_rst) |-> st[AS_TA] && !st[AS_LA])
    else $error("talk only inactive");
  // main scenarios
  cover property (status_flags[EV_APT] && dac_holdoff);
  cover property ($fell(atn_out));
  cover property (st[AS_TA] && st[AS_ATN_N]);
endmodule : tlc_core_props

bind tlc_core tlc_core_props u_tlc_core_props (.clk(clk), .sys_rst(sys_rst), .address_mode_reg(address_mode_reg),
  .talk_only(talk_only), .first_address_reg(first_address_reg), .second_address_reg(second_address_reg),
  .aux_valid(aux_valid), .aux_cmd(aux_cmd), .bus_cmd_valid(bus_cmd_valid), .bus_cmd(bus_cmd),
  .bus_atn_in(bus_atn_in), .bus_byte_done(bus_byte_done), .bus_end_seen(bus_end_seen), .atn_out(atn_out),
  .dac_holdoff(dac_holdoff), .address_status_reg(address_status_reg), .status_flags(status_flags),
  .command_pass_through_reg(command_pass_through_reg));

/* File: testbench/tlc_bus_model.sv */
/* tlc bus model: the other bus devices, sending accepted command
   bytes, handshake events and data bytes. assumes one clock. */
`timescale 1ns/1ps
module tlc_bus_model (
  // clock
  input wire logic clk,
  // from the core and bench
  input wire logic atn_out,
  input wire logic remote_atn,
  input wire logic rx_ready,
  // towards the core
  output logic bus_cmd_valid,
  output logic [7:0] bus_cmd,
  output logic bus_atn_in,
  output logic bus_byte_done,
  output logic bus_end_seen,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  // atn is wired-or of every controller on the bus
  assign bus_atn_in = atn_out || remote_atn;
  initial begin
    bus_cmd_valid = 1'b0;
    bus_cmd = 8'h00;
    bus_byte_done = 1'b0;
    bus_end_seen = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // one accepted command byte; lines show the inverse once released
  task automatic send_cmd(input logic [7:0] b);
    @(posedge clk);
    bus_cmd_valid <= 1'b1;
    bus_cmd <= b;
    @(posedge clk);
    bus_cmd_valid <= 1'b0;
    bus_cmd <= ~b;
    #1;
  endtask : send_cmd
  // byte accepted by all, or end/holdoff seen
  task automatic pulse(input logic is_end);
    @(posedge clk);
    bus_byte_done <= !is_end;
    bus_end_seen <= is_end;
    @(posedge clk);
    bus_byte_done <= 1'b0;
    bus_end_seen <= 1'b0;
    #1;
  endtask : pulse
  // one data byte offered for a cycle; ok tells if it was taken
  task automatic push(input logic [7:0] d, output logic ok);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= d;
    #1;
    ok = rx_ready;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~d;
  endtask : push
endmodule : tlc_bus_model

/* File: testbench/tlc_core_bench.sv */
/* tlc core bench: software strobes and bus traffic in sequence,
   with expected values. assumes the checker binds itself. */
`timescale 1ns/1ps
module tlc_core_bench;
  import tlc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst;
  logic [1:0] mode;
  logic talk_only, listen_only, aux_valid, remote_atn, host_rx_ready;
  logic [3:0] aux_cmd;
  logic [4:0] major_adr, minor_adr; // own primary addresses; minor_adr is changed in mode one
  logic [EV_W-1:0] flag_clear;
  logic bus_cmd_valid, bus_atn_in, bus_byte_done, bus_end_seen, rx_valid, rx_ready, host_rx_valid, atn_out, dac;
  logic [7:0] bus_cmd, rx_data, host_rx_data, cpt;
  logic [AS_W-1:0] st;
  logic [EV_W-1:0] fl;
  logic ok;
  int fail_count = 0;
  int n_checks = 0;
  int i;
  wire [7:0] tl = {6'h00, st[AS_LA], st[AS_TA]}; // listener, talker
  wire [7:0] ps = {6'h00, st[AS_LISTEN_PRIMARY_SEEN_BIT], st[AS_TALK_PRIMARY_SEEN_BIT]}; // primaries seen
  always #5 clk = ~clk;
  tlc_core u_tlc_core (.clk(clk), .sys_rst(sys_rst), .address_mode_reg(mode), .talk_only(talk_only),
    .listen_only(listen_only), .first_address_reg(major_adr), .second_address_reg(minor_adr), .aux_valid(aux_valid),
    .aux_cmd(aux_cmd), .flag_clear(flag_clear), .bus_cmd_valid(bus_cmd_valid), .bus_cmd(bus_cmd),
    .bus_atn_in(bus_atn_in), .bus_byte_done(bus_byte_done), .bus_end_seen(bus_end_seen), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .host_rx_valid(host_rx_valid), .host_rx_ready(host_rx_ready),
    .host_rx_data(host_rx_data), .atn_out(atn_out), .dac_holdoff(dac), .address_status_reg(st),
    .status_flags(fl), .command_pass_through_reg(cpt));
  tlc_bus_model u_tlc_bus_model (.clk(clk), .atn_out(atn_out), .remote_atn(remote_atn), .rx_ready(rx_ready),
    .bus_cmd_valid(bus_cmd_valid), .bus_cmd(bus_cmd), .bus_atn_in(bus_atn_in), .bus_byte_done(bus_byte_done),
    .bus_end_seen(bus_end_seen), .rx_valid(rx_valid), .rx_data(rx_data));
  ////////////////////////////////////////////////////////////////////////////
  // verdict, compares and software strobes
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask : chk_bit
  task automatic aux(input logic [3:0] c);
    @(posedge clk);
    aux_valid <= 1'b1;
    aux_cmd <= c;
    @(posedge clk);
    aux_valid <= 1'b0;
    #1;
  endtask : aux
  // clears every sticky flag in one strobe
  task automatic clr();
    @(posedge clk);
    flag_clear <= '1;
    @(posedge clk);
    flag_clear <= '0;
    #1;
  endtask : clr
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_rst = 1'b1;
    mode = MODE_ONE;
    {talk_only, listen_only, aux_valid, remote_atn, host_rx_ready} = 5'h00;
    aux_cmd = AUX_NOP;
    flag_clear = '0;
    major_adr = 5'h03;
    minor_adr = 5'h07;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("status", 8'h00, {1'b0, st});
    chk("flags", 8'h00, {2'h0, fl});
    u_tlc_bus_model.send_cmd(8'h43);
    chk("ta la", 8'h01, tl);
    chk_bit("address_change_flag", 1'b1, fl[EV_ADDRESS_CHANGE_FLAG]);
    chk_bit("do", 1'b1, fl[EV_DO]);
    chk_bit("atn_n", 1'b1, st[AS_ATN_N]);
    clr();
    u_tlc_bus_model.send_cmd(8'h27);
    chk("ta la", 8'h02, tl);
    chk_bit("di", 1'b0, fl[EV_DI]);
    @(posedge clk);
    remote_atn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_bit("atn_n", 1'b0, st[AS_ATN_N]);
    remote_atn <= 1'b0;
    // fill the fifo while software stalls, then drain it
    ok = 1'b1;
    for (i = 0; i < 8 && ok; i++) u_tlc_bus_model.push(8'ha0 + 8'(i), ok);
    chk("fifo taken", 8'h04, 8'(i - 1));
    chk_bit("di", 1'b1, fl[EV_DI]);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      host_rx_ready <= 1'b1;
      #1;
      chk("rx data", 8'ha0 + 8'(i), host_rx_data);
      @(posedge clk);
      host_rx_ready <= 1'b0;
    end
    #1;
    chk_bit("rx valid", 1'b0, host_rx_valid);
    // minor address moved: listen on the new minor reports minor
    minor_adr <= 5'h0b;
    u_tlc_bus_model.send_cmd(8'h2b);
    chk_bit("major_minor_select_bit", 1'b1, st[AS_MAJOR_MINOR_SELECT_BIT]);
    minor_adr <= 5'h07;
    // mode two: primary then secondary
    mode <= MODE_TWO;
    u_tlc_bus_model.send_cmd(8'h43);
    chk("ps", 8'h01, ps);
    chk_bit("ta", 1'b0, st[AS_TA]);
    clr();
    u_tlc_bus_model.send_cmd(8'h67);
    chk("ta la", 8'h01, tl);
    chk_bit("address_change_flag", 1'b1, fl[EV_ADDRESS_CHANGE_FLAG]);
    u_tlc_bus_model.send_cmd(8'h43);
    u_tlc_bus_model.send_cmd(8'h66);
    chk_bit("ta", 1'b0, st[AS_TA]);
    // mode three: pass-through with valid and non-valid
    mode <= MODE_THREE;
    u_tlc_bus_model.send_cmd(8'h27);
    chk("ps", 8'h02, ps);
    u_tlc_bus_model.send_cmd(8'h65);
    chk_bit("apt", 1'b1, fl[EV_APT]);
    chk_bit("dac", 1'b1, dac);
    chk("cpt", 8'h65, cpt);
    aux(AUX_VALID);
    chk("ta la", 8'h02, tl);
    chk_bit("dac", 1'b0, dac);
    clr();
    u_tlc_bus_model.send_cmd(8'h69);
    chk_bit("apt", 1'b1, fl[EV_APT]);
    aux(AUX_NONVALID);
    chk("ta la", 8'h00, tl);
    chk_bit("dac", 1'b0, dac);
    u_tlc_bus_model.send_cmd(8'h14);
    chk("ps", 8'h00, ps);
    clr();
    u_tlc_bus_model.send_cmd(8'h6a);
    chk_bit("apt", 1'b0, fl[EV_APT]);
    // talk primary, secondary, valid: talker addressed
    u_tlc_bus_model.send_cmd(8'h43);
    u_tlc_bus_model.send_cmd(8'h61);
    aux(AUX_VALID);
    chk("ta la", 8'h01, tl);
    // controller: take, listen, standby and hand-back paths
    aux(AUX_BECOME_CIC);
    chk_bit("atn", 1'b1, atn_out);
    chk_bit("co", 1'b1, fl[EV_CO]);
    aux(AUX_LISTEN);
    chk("ta la", 8'h02, tl);
    aux(AUX_LUNL);
    chk("ta la", 8'h00, tl);
    #1;
    chk_bit("atn_n", 1'b0, st[AS_ATN_N]);
    aux(AUX_GTS);
    clr();
    aux(AUX_TCA);
    chk_bit("atn", 1'b1, atn_out);
    chk_bit("co", 1'b1, fl[EV_CO]);
    aux(AUX_GTS);
    clr();
    aux(AUX_TCS);
    chk_bit("atn", 1'b0, atn_out);
    u_tlc_bus_model.pulse(1'b0);
    chk_bit("atn", 1'b1, atn_out);
    chk_bit("co", 1'b1, fl[EV_CO]);
    aux(AUX_GTS);
    aux(AUX_TCS);
    u_tlc_bus_model.pulse(1'b1);
    chk_bit("atn", 1'b1, atn_out);
    chk_bit("end", 1'b1, fl[EV_END]);
    u_tlc_bus_model.send_cmd(8'h4c);
    u_tlc_bus_model.pulse(1'b0);
    u_tlc_bus_model.send_cmd(CMD_TCT);
    u_tlc_bus_model.pulse(1'b0);
    chk("atn cic", 8'h00, {6'h00, atn_out, st[AS_CIC]});
    // programmed talker then listener
    talk_only <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("ta la", 8'h01, tl);
    talk_only <= 1'b0;
    listen_only <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("ta la", 8'h02, tl);
    report_and_stop();
  end
endmodule : tlc_core_bench
